// ---- dual_clock_fifo_offset_mailbox_ctrl.sv ----
`timescale 1ns/100ps
`include "fifo_ctrl_params.svh"

// ****************************************
// staging buffer between port a and array
// ****************************************
module staging_fifo #(
	parameter int WIDTH = `DATA_W,
	parameter int DEPTH = `STAGE_DEPTH
) (
	input  wire logic             clk_sys_i,
	input  wire logic             resetn_i,
	input  wire logic             flush_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [AW:0]      wr;
	logic [AW:0]      rd;
	logic [AW:0]      next_wr;
	logic [AW:0]      next_rd;
	logic             push;
	logic             pop;

	assign in_ready_o  = (wr - rd) != (AW+1)'(DEPTH);
	assign out_valid_o = wr != rd;
	assign out_data_o  = store[rd[AW-1:0]];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always_comb begin
		next_wr = wr;
		next_rd = rd;
		if (flush_i) begin
			next_wr = '0;
			next_rd = '0;
		end else begin
			if (push)
				next_wr = wr + 1'b1;
			if (pop)
				next_rd = rd + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr <= '0;
			rd <= '0;
		end else begin
			wr <= next_wr;
			rd <= next_rd;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (push && !flush_i)
			store[wr[AW-1:0]] <= in_data_i;
	end
endmodule : staging_fifo

// ****************************************
// fifo control, offsets and mailboxes
// ****************************************
module dual_clock_fifo_offset_mailbox_ctrl
	import fifo_ctrl_pkg::*;
#(
	parameter int DATA_W   = `DATA_W,
	parameter int ADDR_W   = `ADDR_W,
	parameter int STAGE_D  = `STAGE_DEPTH
) (
	input  wire logic              clk_sys_i,
	input  wire logic              resetn_i,
	input  wire logic              fifo_reset_n_i,
	input  wire logic              flag_select_hi_serial_enable_i,
	input  wire logic              flag_select_lo_serial_data_i,
	input  wire logic              port_a_clock_i,
	input  wire logic              port_a_select_n_i,
	input  wire logic              port_a_master_enable_i,
	input  wire logic              port_a_direction_select_i,
	input  wire logic              port_a_mailbox_select_i,
	input  wire logic [DATA_W-1:0] port_a_data_i,
	output logic      [DATA_W-1:0] port_a_data_o,
	output logic                   port_a_data_oe_n_o,
	input  wire logic              port_b_clock_i,
	input  wire logic              port_b_select_n_i,
	input  wire logic              port_b_master_enable_i,
	input  wire logic              port_b_direction_select_i,
	input  wire logic              port_b_mailbox_select_i,
	input  wire logic              read_from_mark_i,
	input  wire logic              retransmit_mode_select_i,
	input  wire logic [DATA_W-1:0] port_b_data_i,
	output logic      [DATA_W-1:0] port_b_data_o,
	output logic                   port_b_data_oe_n_o,
	output logic                   input_ready_flag_o,
	output logic                   output_ready_flag_o,
	output logic                   almost_empty_flag_o,
	output logic                   almost_full_flag_o,
	output logic                   a_to_b_mail_flag_o,
	output logic                   b_to_a_mail_flag_o
);
	import fifo_ctrl_pkg::*;

	localparam int          PW    = ADDR_W + 1;
	localparam int          CW    = ADDR_W + 2;
	localparam logic [CW-1:0] DEPTH = CW'(1) << ADDR_W;
	localparam int          SCW   = $clog2(STAGE_D + 1);

	function automatic logic port_strobe(input logic edge_s, input logic sel_n, input logic en);
		port_strobe = edge_s & ~sel_n & en;
	endfunction : port_strobe

	function automatic offset_mode_t decode_mode(input logic hi, input logic lo);
		case ({hi, lo})
			2'b11:   decode_mode = MODE_SERIAL;
			2'b10:   decode_mode = MODE_PRESET_HI;
			2'b01:   decode_mode = MODE_PRESET_LO;
			default: decode_mode = MODE_PARALLEL;
		endcase
	endfunction : decode_mode

	// ****************************************
	// pin synchronisers
	// ****************************************
	// all pins are foreign to clk_sys_i; port clocks are sampled, so each
	// must stay high and low for more than two system clock periods
	port_a_pins_t a_s1, a_s2;
	port_b_pins_t b_s1, b_s2;
	misc_pins_t   m_s1, m_s2;
	logic         a_clk_prev, b_clk_prev, rst_prev;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			a_s1       <= '0;
			a_s2       <= '0;
			b_s1       <= '0;
			b_s2       <= '0;
			m_s1       <= '0;
			m_s2       <= '0;
			a_clk_prev <= 1'b0;
			b_clk_prev <= 1'b0;
			rst_prev   <= 1'b0;
		end else begin
			a_s1       <= '{port_a_clock_i, port_a_select_n_i, port_a_master_enable_i,
				port_a_direction_select_i, port_a_mailbox_select_i, port_a_data_i};
			b_s1       <= '{port_b_clock_i, port_b_select_n_i, port_b_master_enable_i,
				port_b_direction_select_i, port_b_mailbox_select_i, read_from_mark_i,
				retransmit_mode_select_i, port_b_data_i};
			m_s1       <= '{fifo_reset_n_i, flag_select_hi_serial_enable_i, flag_select_lo_serial_data_i};
			a_s2       <= a_s1;
			b_s2       <= b_s1;
			m_s2       <= m_s1;
			a_clk_prev <= a_s2.clk;
			b_clk_prev <= b_s2.clk;
			rst_prev   <= m_s2.rst_n;
		end
	end

	// ****************************************
	// strobes
	// ****************************************
	logic a_edge, b_edge, a_act, b_act, rst_rise;
	logic a_fifo_wr, a_mail_wr, a_mail_rd;
	logic b_fifo_rd, b_mail_wr, b_mail_rd;

	assign a_edge    = a_s2.clk & ~a_clk_prev;
	assign b_edge    = b_s2.clk & ~b_clk_prev;
	assign rst_rise  = m_s2.rst_n & ~rst_prev;
	assign a_act     = port_strobe(a_edge, a_s2.sel_n, a_s2.en);
	assign b_act     = port_strobe(b_edge, b_s2.sel_n, b_s2.en);
	assign a_fifo_wr = a_act & a_s2.dir & ~a_s2.mbx & input_ready_flag_o;
	assign a_mail_wr = a_act & a_s2.dir & a_s2.mbx;
	assign a_mail_rd = a_act & ~a_s2.dir & a_s2.mbx;
	assign b_fifo_rd = b_act & b_s2.dir & ~b_s2.mbx;
	assign b_mail_wr = b_act & ~b_s2.dir & b_s2.mbx;
	assign b_mail_rd = b_act & b_s2.dir & b_s2.mbx;

	// ****************************************
	// array and staging
	// ****************************************
	logic [DATA_W-1:0] mem [1 << ADDR_W];
	logic [PW-1:0]     wr_ptr, rd_ptr, mark;
	logic [SCW-1:0]    stage_cnt;
	logic              stage_in_ready, stage_valid, pop, push, flush;
	logic [DATA_W-1:0] stage_data;
	logic [PW-1:0]     used_rd, base_used;
	logic [CW-1:0]     words_b, words_a, empty_a;
	logic              rt_mode;
	phase_t            phase;

	assign flush     = ~m_s2.rst_n;
	assign push      = a_fifo_wr & (phase == PH_RUN);
	assign used_rd   = wr_ptr - rd_ptr;
	assign base_used = wr_ptr - (rt_mode ? mark : rd_ptr);
	// a retained mark holds its locations, so it limits the drain as well
	assign pop       = stage_valid & (CW'(base_used) < DEPTH) & (phase == PH_RUN);

	staging_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (STAGE_D)
	) u_stage (
		.clk_sys_i   (clk_sys_i),
		.resetn_i    (resetn_i),
		.flush_i     (flush),
		.in_valid_i  (push),
		.in_ready_o  (stage_in_ready),
		.in_data_i   (a_s2.data),
		.out_valid_o (stage_valid),
		.out_ready_i (pop),
		.out_data_o  (stage_data)
	);

	always_ff @(posedge clk_sys_i) begin
		if (pop)
			mem[wr_ptr[ADDR_W-1:0]] <= stage_data;
	end

	// ****************************************
	// control state
	// ****************************************
	logic [`OFFSET_W-1:0] ae_off, af_off, next_ae_off, next_af_off;
	logic [2*`OFFSET_W-1:0] shifted;
	logic [4:0]           cnt, next_cnt;
	logic [1:0]           age, next_age;
	logic [DATA_W-1:0]    out_reg, next_out_reg, a_to_b_mailbox, b_to_a_mailbox;
	logic [DATA_W-1:0]    next_a_to_b, next_b_to_a, next_a_data, next_b_data;
	logic [PW-1:0]        next_wr_ptr, next_rd_ptr, next_mark;
	logic [SCW-1:0]       next_stage_cnt;
	logic                 next_rt_mode, next_ir, next_or, next_ae, next_af;
	logic                 next_mf_ab, next_mf_ba, next_a_oe_n, next_b_oe_n;
	phase_t               next_phase;

	// parallel mode remembered from the latch for the init exit
	logic mode_is_parallel, next_mode_is_parallel;
	assign next_mode_is_parallel = rst_rise ? (decode_mode(m_s2.fs_hi, m_s2.fs_lo) == MODE_PARALLEL)
		: mode_is_parallel;

	function automatic logic retransmit_mode_select_check(input logic retransmit_mode_select, input logic in_mode, input logic ready);
		retransmit_mode_select_check = retransmit_mode_select & ~in_mode & ready;
	endfunction : retransmit_mode_select_check

	assign words_b = CW'(used_rd) + CW'(output_ready_flag_o);
	assign words_a = words_b + CW'(stage_cnt);
	// output register word can lift the count one past the array; clamp, no wrap
	assign empty_a = (words_a >= DEPTH) ? '0 : DEPTH - words_a;
	assign shifted = {af_off[`OFFSET_W-2:0], ae_off, m_s2.fs_lo};

	always_comb begin
		next_phase     = phase;
		next_cnt       = cnt;
		next_ae_off    = ae_off;
		next_af_off    = af_off;
		next_wr_ptr    = wr_ptr;
		next_rd_ptr    = rd_ptr;
		next_mark      = mark;
		next_rt_mode   = rt_mode;
		next_age       = age;
		next_out_reg   = out_reg;
		next_ir        = input_ready_flag_o;
		next_or        = output_ready_flag_o;
		next_ae        = almost_empty_flag_o;
		next_af        = almost_full_flag_o;
		next_mf_ab     = a_to_b_mail_flag_o;
		next_mf_ba     = b_to_a_mail_flag_o;
		next_a_to_b    = a_to_b_mailbox;
		next_b_to_a    = b_to_a_mailbox;
		next_stage_cnt = stage_cnt + SCW'(push) - SCW'(pop);
		if (pop)
			next_wr_ptr = wr_ptr + 1'b1;

		// mailboxes; a write in the same cycle as a read leaves the flag low
		if (a_mail_rd)
			next_mf_ba = 1'b1;
		if (b_mail_wr) begin
			next_b_to_a = b_s2.data;
			next_mf_ba  = 1'b0;
		end
		if (b_mail_rd)
			next_mf_ab = 1'b1;
		if (a_mail_wr) begin
			next_a_to_b = a_s2.data;
			next_mf_ab  = 1'b0;
		end

		// read side: word becomes visible on the third port-b edge
		if (pop && used_rd == '0)
			next_age = 2'd0;
		else if (b_edge && age != 2'(`OR_LATENCY))
			next_age = age + 1'b1;
		if (b_edge) begin
			if (retransmit_mode_select_check(b_s2.retransmit_mode_select, rt_mode, output_ready_flag_o)) begin
				next_mark    = rd_ptr - 1'b1;
				next_rt_mode = 1'b1;
			end else if (!b_s2.retransmit_mode_select) begin
				next_rt_mode = 1'b0;
			end
			if (rt_mode && b_s2.read_from_mark) begin
				next_out_reg = mem[mark[ADDR_W-1:0]];
				next_rd_ptr  = mark + 1'b1;
				next_or      = 1'b1;
			end else if (used_rd != '0 && age >= 2'(`OR_LATENCY - 1)
				&& (!output_ready_flag_o || b_fifo_rd)) begin
				next_out_reg = mem[rd_ptr[ADDR_W-1:0]];
				next_rd_ptr  = rd_ptr + 1'b1;
				next_or      = 1'b1;
			end else if (b_fifo_rd) begin
				next_or = 1'b0;
			end
			next_ae = words_b > CW'(ae_off);
		end

		if (a_edge) begin
			next_af = empty_a > CW'(af_off);
		end

		case (phase)
			PH_RESET: begin
				next_ir = 1'b0;
			end
			PH_INIT: begin
				if (a_edge) begin
					next_cnt = cnt + 1'b1;
					if (cnt == 5'(`INIT_A_EDGES - 1)) begin
						next_ir    = 1'b1;
						next_phase = (mode_is_parallel) ? PH_PARALLEL : PH_RUN;
					end
				end
			end
			PH_SERIAL: begin
				if (a_edge && !m_s2.fs_hi) begin
					next_af_off = shifted[2*`OFFSET_W-1:`OFFSET_W];
					next_ae_off = shifted[`OFFSET_W-1:0];
					next_cnt    = cnt + 1'b1;
					if (cnt == 5'(`SERIAL_BITS - 1)) begin
						next_cnt   = 5'(`INIT_A_EDGES - 1);
						next_phase = PH_INIT;
					end
				end
			end
			PH_PARALLEL: begin
				if (a_fifo_wr) begin
					next_cnt = cnt + 1'b1;
					if (cnt[0] == 1'b0) begin
						next_af_off = a_s2.data[`OFFSET_W-1:0];
					end else begin
						next_ae_off = a_s2.data[`OFFSET_W-1:0];
						next_phase  = PH_RUN;
					end
				end
			end
			PH_RUN: begin
				if (a_edge)
					next_ir = (CW'(base_used) + CW'(next_stage_cnt) < DEPTH)
						&& (next_stage_cnt < SCW'(STAGE_D)) && stage_in_ready;
			end
			default: begin
				next_phase = PH_RESET;
			end
		endcase

		// reset pin overrides phase, pointers and flags; preset offsets are loaded at its release
		if (!m_s2.rst_n) begin
			next_phase     = PH_RESET;
			next_wr_ptr    = '0;
			next_rd_ptr    = '0;
			next_mark      = '0;
			next_rt_mode   = 1'b0;
			next_stage_cnt = '0;
			next_age       = 2'(`OR_LATENCY);
			next_ir        = 1'b0;
			next_or        = 1'b0;
			next_ae        = 1'b0;
			next_af        = 1'b1;
			next_mf_ab     = 1'b1;
			next_mf_ba     = 1'b1;
		end else if (rst_rise) begin
			next_cnt = '0;
			case (decode_mode(m_s2.fs_hi, m_s2.fs_lo))
				MODE_SERIAL: begin
					next_phase = PH_SERIAL;
				end
				MODE_PRESET_HI: begin
					next_ae_off = `PRESET_HI;
					next_af_off = `PRESET_HI;
					next_phase  = PH_INIT;
				end
				MODE_PRESET_LO: begin
					next_ae_off = `PRESET_LO;
					next_af_off = `PRESET_LO;
					next_phase  = PH_INIT;
				end
				default: begin
					next_phase = PH_INIT;
				end
			endcase
		end

		// data pins: output enables are active low
		next_a_data = next_b_to_a;
		next_b_data = b_s2.mbx ? next_a_to_b : next_out_reg;
		next_a_oe_n = a_s2.sel_n | a_s2.dir;
		next_b_oe_n = b_s2.sel_n | ~b_s2.dir;
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			phase               <= PH_RESET;
			mode_is_parallel    <= 1'b0;
			cnt                 <= '0;
			ae_off              <= '0;
			af_off              <= '0;
			wr_ptr              <= '0;
			rd_ptr              <= '0;
			mark                <= '0;
			rt_mode             <= 1'b0;
			stage_cnt           <= '0;
			age                 <= 2'(`OR_LATENCY);
			out_reg             <= '0;
			a_to_b_mailbox      <= '0;
			b_to_a_mailbox      <= '0;
			input_ready_flag_o  <= 1'b0;
			output_ready_flag_o <= 1'b0;
			almost_empty_flag_o <= 1'b0;
			almost_full_flag_o  <= 1'b1;
			a_to_b_mail_flag_o  <= 1'b1;
			b_to_a_mail_flag_o  <= 1'b1;
			port_a_data_o       <= '0;
			port_b_data_o       <= '0;
			port_a_data_oe_n_o  <= 1'b1;
			port_b_data_oe_n_o  <= 1'b1;
		end else begin
			phase               <= next_phase;
			mode_is_parallel    <= next_mode_is_parallel;
			cnt                 <= next_cnt;
			ae_off              <= next_ae_off;
			af_off              <= next_af_off;
			wr_ptr              <= next_wr_ptr;
			rd_ptr              <= next_rd_ptr;
			mark                <= next_mark;
			rt_mode             <= next_rt_mode;
			stage_cnt           <= next_stage_cnt;
			age                 <= next_age;
			out_reg             <= next_out_reg;
			a_to_b_mailbox      <= next_a_to_b;
			b_to_a_mailbox      <= next_b_to_a;
			input_ready_flag_o  <= next_ir;
			output_ready_flag_o <= next_or;
			almost_empty_flag_o <= next_ae;
			almost_full_flag_o  <= next_af;
			a_to_b_mail_flag_o  <= next_mf_ab;
			b_to_a_mail_flag_o  <= next_mf_ba;
			port_a_data_o       <= next_a_data;
			port_b_data_o       <= next_b_data;
			port_a_data_oe_n_o  <= next_a_oe_n;
			port_b_data_oe_n_o  <= next_b_oe_n;
		end
	end
endmodule : dual_clock_fifo_offset_mailbox_ctrl

// ---- fifo_ctrl_params.svh ----
`ifndef FIFO_CTRL_PARAMS_SVH
`define FIFO_CTRL_PARAMS_SVH
// Overview of operation
// - serial mode: port-a edge with serial enable low shifts serial data into offsets
// - twenty serial bits, almost-full msb first, almost-empty lsb last
// - input ready changes on port-a edges; low means full, writes ignored
// - retransmit mode: input ready drops when writes reach the marked data
// - reset clears pointers, ready flags low, almost-empty low, almost-full high, mail flags high
// - reset pin is asynchronous to port clocks and is synchronised
// - reset pin rise latches flag selects: serial, 64, 8 or parallel
// - port-a mailbox select steers port-a access to a mailbox
// - port-b mailbox select picks a-to-b mailbox or fifo output register for output
// - a-to-b mail flag low on port-a mailbox write, high on port-b mailbox read
// - b-to-a mail flag low on port-b mailbox write, high on port-a mailbox read
// - output ready changes on port-b edges; low means empty, reads ignored
// - output ready low in reset, rises third port-b edge after first word
// - read from mark shows marked word as first retransmit word and reloads read pointer with mark + 1
// - retransmit select with output ready marks current word; low select exits mode
// - port-a direction high writes, low reads; port-a data floats when high
// - port-b direction low writes, high reads; port-b data floats when low
// - preset modes load offsets and raise input ready after two port-a edges
// - parallel mode: first two fifo writes load almost-full then almost-empty offsets
// - parallel offset is low ten port-a data bits, legal 1 to 1020
// - almost-empty low while stored words not above almost-empty offset
// - almost-full low while empty locations not above almost-full offset
// - serial mode keeps input ready low until last bit, rises next port-a edge
`define DATA_W        36
`define ADDR_W        10
`define OFFSET_W      10
`define STAGE_DEPTH   16
`define SERIAL_BITS   20
`define PRESET_HI     10'h040
`define PRESET_LO     10'h008
`define INIT_A_EDGES  2
`define OR_LATENCY    3
`endif

// ---- fifo_ctrl_pkg.sv ----
`include "fifo_ctrl_params.svh"
package fifo_ctrl_pkg;
	typedef enum logic [1:0] {MODE_SERIAL, MODE_PRESET_HI, MODE_PRESET_LO, MODE_PARALLEL} offset_mode_t;
	typedef enum logic [2:0] {PH_RESET, PH_INIT, PH_SERIAL, PH_PARALLEL, PH_RUN} phase_t;
	typedef struct packed {
		logic                clk;
		logic                sel_n;
		logic                en;
		logic                dir;
		logic                mbx;
		logic [`DATA_W-1:0]  data;
	} port_a_pins_t;
	typedef struct packed {
		logic                clk;
		logic                sel_n;
		logic                en;
		logic                dir;
		logic                mbx;
		logic                read_from_mark;
		logic                retransmit_mode_select;
		logic [`DATA_W-1:0]  data;
	} port_b_pins_t;
	typedef struct packed {
		logic  rst_n;
		logic  fs_hi;
		logic  fs_lo;
	} misc_pins_t;
endpackage : fifo_ctrl_pkg

// ---- fifo_ctrl_chk_asserts.sv ----
`timescale 1ns/100ps
// ****************************************
// port checks of the fifo control block
// ****************************************
module fifo_ctrl_chk (
	input  wire logic clk_sys_i,
	input  wire logic resetn_i,
	input  wire logic fifo_reset_n_i,
	input  wire logic port_a_clock_i,
	input  wire logic port_b_clock_i,
	input  wire logic port_a_direction_select_i,
	input  wire logic port_a_mailbox_select_i,
	input  wire logic port_b_direction_select_i,
	input  wire logic port_b_mailbox_select_i,
	input  wire logic port_a_data_oe_n_o,
	input  wire logic port_b_data_oe_n_o,
	input  wire logic input_ready_flag_o,
	input  wire logic output_ready_flag_o,
	input  wire logic almost_empty_flag_o,
	input  wire logic almost_full_flag_o,
	input  wire logic a_to_b_mail_flag_o,
	input  wire logic b_to_a_mail_flag_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// five samples cover two sync stages plus the flag register
	property p_reset_flags;
		!fifo_reset_n_i [*5] |-> !input_ready_flag_o && !output_ready_flag_o && !almost_empty_flag_o
			&& almost_full_flag_o && a_to_b_mail_flag_o && b_to_a_mail_flag_o;
	endproperty
	a_reset_flags: assert property (p_reset_flags) else $error("flags wrong while reset pin low");
	property p_a_float;
		port_a_direction_select_i [*4] |-> port_a_data_oe_n_o;
	endproperty
	a_a_float: assert property (p_a_float) else $error("port a driven during write select");
	property p_b_float;
		!port_b_direction_select_i [*4] |-> port_b_data_oe_n_o;
	endproperty
	a_b_float: assert property (p_b_float) else $error("port b driven during write select");
	property p_ir_edge;
		$rose(input_ready_flag_o) |-> $past(port_a_clock_i, 3);
	endproperty
	a_ir_edge: assert property (p_ir_edge) else $error("input ready rose away from port a edge");
	property p_or_edge;
		$rose(output_ready_flag_o) |-> $past(port_b_clock_i, 3);
	endproperty
	a_or_edge: assert property (p_or_edge) else $error("output ready rose away from port b edge");
	// pins reach the strobe through two stages, the flag one register later
	property p_ab_mail;
		$fell(a_to_b_mail_flag_o) |-> $past(port_a_mailbox_select_i, 3) && $past(port_a_direction_select_i, 3);
	endproperty
	a_ab_mail: assert property (p_ab_mail) else $error("a to b flag fell without mailbox write");
	property p_ba_mail;
		$fell(b_to_a_mail_flag_o) |-> $past(port_b_mailbox_select_i, 3) && !$past(port_b_direction_select_i, 3);
	endproperty
	a_ba_mail: assert property (p_ba_mail) else $error("b to a flag fell without mailbox write");
	property p_ir_late;
		$rose(fifo_reset_n_i) |-> !input_ready_flag_o [*8];
	endproperty
	a_ir_late: assert property (p_ir_late) else $error("input ready rose too soon after reset");
endmodule : fifo_ctrl_chk

bind dual_clock_fifo_offset_mailbox_ctrl fifo_ctrl_chk chk_i (.*);

// ---- port_clock_gen.sv ----
`timescale 1ns/100ps
// ****************************************
// free-running clock of a port master
// ****************************************
module port_clock_gen #(
	parameter int HALF_NS  = 50,
	parameter int START_NS = 0
) (
	output logic clk_o
);
	// never stops; the block samples it, so each phase spans >= 3 system clocks
	initial begin
		clk_o = 1'b0;
		#(START_NS);
		forever #(HALF_NS) clk_o = ~clk_o;
	end
endmodule : port_clock_gen

// ---- testbench.sv ----
`timescale 1ns/100ps
`include "fifo_ctrl_params.svh"
module testbench;
	import fifo_ctrl_pkg::*;
	localparam logic [19:0] SER_WORD = {10'h200, 10'h001};
	logic               clk_sys_i, resetn_i, fifo_reset_n_i;
	logic               flag_select_hi_serial_enable_i, flag_select_lo_serial_data_i;
	logic               port_a_clock_i, port_a_select_n_i, port_a_master_enable_i;
	logic               port_a_direction_select_i, port_a_mailbox_select_i;
	logic               port_b_clock_i, port_b_select_n_i, port_b_master_enable_i;
	logic               port_b_direction_select_i, port_b_mailbox_select_i;
	logic               read_from_mark_i, retransmit_mode_select_i;
	logic               port_a_data_oe_n_o, port_b_data_oe_n_o, input_ready_flag_o, output_ready_flag_o;
	logic               almost_empty_flag_o, almost_full_flag_o, a_to_b_mail_flag_o, b_to_a_mail_flag_o;
	logic [`DATA_W-1:0] port_a_data_i, port_a_data_o, port_b_data_i, port_b_data_o;
	int                 mismatches, checks, n, k;

	dual_clock_fifo_offset_mailbox_ctrl uut (.*);
	port_clock_gen #(.HALF_NS(50), .START_NS(3)) clk_a_gen (.clk_o(port_a_clock_i));
	port_clock_gen #(.HALF_NS(45), .START_NS(17)) clk_b_gen (.clk_o(port_b_clock_i));

	always #5 clk_sys_i = ~clk_sys_i;

	task automatic chk(input logic [`DATA_W-1:0] got, input logic [`DATA_W-1:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one access per port edge; enable dropped before the next edge
	task automatic pa(input logic dir, input logic mbx, input logic [`DATA_W-1:0] d);
		@(negedge port_a_clock_i);
		@(posedge clk_sys_i);
		#1 {port_a_master_enable_i, port_a_direction_select_i, port_a_mailbox_select_i, port_a_data_i} = {1'b1, dir, mbx, d};
		@(negedge port_a_clock_i);
		@(posedge clk_sys_i);
		#1 {port_a_master_enable_i, port_a_direction_select_i, port_a_mailbox_select_i} = 3'b010;
		@(negedge port_a_clock_i);
	endtask : pa

	// mailbox select kept after the access so its output can be seen
	task automatic pb(input logic dir, input logic mbx, input logic [`DATA_W-1:0] d);
		@(negedge port_b_clock_i);
		@(posedge clk_sys_i);
		#1 {port_b_master_enable_i, port_b_direction_select_i, port_b_mailbox_select_i, port_b_data_i} = {1'b1, dir, mbx, d};
		@(negedge port_b_clock_i);
		@(posedge clk_sys_i);
		#1 {port_b_master_enable_i, port_b_direction_select_i} = 2'b01;
		@(negedge port_b_clock_i);
	endtask : pb

	task automatic frst(input logic hi, input logic lo);
		@(posedge clk_sys_i);
		#1 {fifo_reset_n_i, flag_select_hi_serial_enable_i, flag_select_lo_serial_data_i} = {1'b0, hi, lo};
		repeat (5) @(posedge port_a_clock_i);
		repeat (5) @(posedge port_b_clock_i);
		@(posedge clk_sys_i);
		#1 fifo_reset_n_i = 1'b1;
		repeat (4) @(negedge port_a_clock_i);
	endtask : frst

	task automatic results;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	// a full fill and drain dominates the run time
	initial begin
		#1_000_000;
		mismatches++;
		results();
	end

	initial begin
		{clk_sys_i, resetn_i, fifo_reset_n_i, read_from_mark_i, retransmit_mode_select_i} = 5'b0;
		{flag_select_hi_serial_enable_i, flag_select_lo_serial_data_i} = 2'b01;
		{port_a_select_n_i, port_a_master_enable_i, port_a_direction_select_i, port_a_mailbox_select_i} = 4'b0010;
		{port_b_select_n_i, port_b_master_enable_i, port_b_direction_select_i, port_b_mailbox_select_i} = 4'b0010;
		{port_a_data_i, port_b_data_i, mismatches, checks} = '0;
		repeat (6) @(posedge clk_sys_i);
		#1 resetn_i = 1'b1;
		repeat (8) @(posedge clk_sys_i);
		chk({input_ready_flag_o, output_ready_flag_o, almost_empty_flag_o, almost_full_flag_o,
			a_to_b_mail_flag_o, b_to_a_mail_flag_o}, 6'b000111);
		frst(1'b0, 1'b1);
		chk(input_ready_flag_o, 1'b1);
		$display("test reset and preset done");
		pa(1'b1, 1'b1, 36'h9_1234_5678);
		chk(a_to_b_mail_flag_o, 1'b0);
		pb(1'b1, 1'b1, '0);
		chk(port_b_data_o, 36'h9_1234_5678);
		chk(a_to_b_mail_flag_o, 1'b1);
		pb(1'b0, 1'b1, 36'h5_a5a5_0f0f);
		chk(b_to_a_mail_flag_o, 1'b0);
		pa(1'b0, 1'b1, '0);
		chk(port_a_data_o, 36'h5_a5a5_0f0f);
		chk(b_to_a_mail_flag_o, 1'b1);
		$display("test mailboxes done");
		// fifo data only shows with the port-b mailbox select low
		@(posedge clk_sys_i);
		#1 port_b_mailbox_select_i = 1'b0;
		for (k = 0; k < 10; k++) begin
			pa(1'b1, 1'b0, 36'h100 + 36'(k));
			repeat (5) @(negedge port_b_clock_i);
			if (k == 0) begin
				chk(output_ready_flag_o, 1'b1);
				chk(port_b_data_o, 36'h100);
				chk(almost_empty_flag_o, 1'b0);
			end
		end
		chk(almost_empty_flag_o, 1'b1);
		for (k = 1; k < 11; k++) begin
			pb(1'b1, 1'b0, '0);
			chk(port_b_data_o, 36'h100 + 36'(k < 10 ? k : 9));
		end
		chk(output_ready_flag_o, 1'b0);
		$display("test fifo order done");
		n = 0;
		while (input_ready_flag_o === 1'b1 && n < 1100) begin
			pa(1'b1, 1'b0, 36'(n));
			n++;
		end
		chk(input_ready_flag_o, 1'b0);
		chk(almost_full_flag_o, 1'b0);
		pa(1'b1, 1'b0, 36'hd_eadb_eef0);
		chk(almost_full_flag_o, 1'b0);
		for (k = 1; k <= n; k++) begin
			pb(1'b1, 1'b0, '0);
			chk(port_b_data_o, 36'(k < n ? k : n - 1));
		end
		chk(output_ready_flag_o, 1'b0);
		$display("test full refusal done");
		frst(1'b0, 1'b0);
		pa(1'b1, 1'b0, 36'hf_ffff_fc05);
		pa(1'b1, 1'b0, 36'hf_ffff_fc02);
		for (k = 0; k < 4; k++)
			pa(1'b1, 1'b0, 36'h300 + 36'(k));
		repeat (5) @(negedge port_b_clock_i);
		chk(port_b_data_o, 36'h300);
		chk(almost_empty_flag_o, 1'b1);
		$display("test parallel offsets done");
		frst(1'b1, 1'b1);
		for (k = 19; k >= 0; k--) begin
			@(negedge port_a_clock_i);
			@(posedge clk_sys_i);
			#1 {flag_select_hi_serial_enable_i, flag_select_lo_serial_data_i} = {1'b0, SER_WORD[k]};
			if (k == 0)
				chk(input_ready_flag_o, 1'b0);
			@(negedge port_a_clock_i);
			@(posedge clk_sys_i);
			#1 flag_select_hi_serial_enable_i = 1'b1;
		end
		repeat (2) @(negedge port_a_clock_i);
		chk(input_ready_flag_o, 1'b1);
		for (k = 0; k < 4; k++)
			pa(1'b1, 1'b0, 36'h400 + 36'(k));
		repeat (5) @(negedge port_b_clock_i);
		chk(almost_empty_flag_o, 1'b1);
		$display("test serial offsets done");
		// mark the shown word, read on, then rewind to the mark
		@(posedge clk_sys_i);
		#1 retransmit_mode_select_i = 1'b1;
		repeat (2) @(negedge port_b_clock_i);
		pb(1'b1, 1'b0, '0);
		chk(port_b_data_o, 36'h401);
		@(posedge clk_sys_i);
		#1 read_from_mark_i = 1'b1;
		repeat (2) @(negedge port_b_clock_i);
		@(posedge clk_sys_i);
		#1 read_from_mark_i = 1'b0;
		chk(port_b_data_o, 36'h400);
		pb(1'b1, 1'b0, '0);
		chk(port_b_data_o, 36'h401);
		$display("test retransmit done");
		results();
	end
endmodule : testbench
